// ==== design/timer_defs.svh ====
// Register indices, field positions and reset values of the timer.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
// Register indices; the byte address is four times the index.
`define TMR_IDX_CTRL   6'h00
`define TMR_IDX_CNTH   6'h01
`define TMR_IDX_CNTL   6'h02
`define TMR_IDX_MODH   6'h03
`define TMR_IDX_MODL   6'h04
`define TMR_CH_BASE    5
`define TMR_CH_STRIDE  3
`define TMR_CH_CTRL    0
`define TMR_CH_VHI     1
`define TMR_CH_VLO     2
// Timer control byte fields.
`define TMR_TOF_BIT    7
`define TMR_OVERFLOW_IRQ_ENABLE_BIT   6
`define TMR_CAS_BIT    5
`define TMR_CLKS_HI    4
`define TMR_CLKS_LO    3
// Channel control byte fields.
`define TMR_CHF_BIT    7
`define TMR_CHCFG_HI   6
`define TMR_CHCFG_LO   2
// Reset values and bus answers.
`define TMR_CNT_RST    16'h0000
`define TMR_VAL_RST    16'h0000
`define TMR_CNT_MAX    16'hffff
`define TMR_RESP_OKAY  2'h0
`define TMR_RESP_DEC   2'h3
`endif

// ==== design/timer_pkg.sv ====
// Types shared by the timer design.
`default_nettype none
package timer_pkg;
  // Counter clock source choices.
  typedef enum logic [1:0] {
    CLK_NONE,
    CLK_BUS,
    CLK_FIXED,
    CLK_EXT
  } clk_sel_e;

  // Channel operating modes.
  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_EDGE_PWM,
    MODE_CENTER_PWM
  } chan_mode_e;

  // Software-written channel configuration.
  typedef struct packed {
    logic       channel_irq_enable;
    logic       mode_select_upper;
    logic       mode_select_lower;
    logic [1:0] edge_level_select;
  } ch_ctrl_s;
endpackage
`default_nettype wire

// ==== design/timer_pwm_unit.sv ====
// Timer with shared counter, capture, compare and PWM channels behind AXI4-Lite.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`default_nettype none
`include "timer_defs.svh"

// Contract
// - Channel values clear to zero on reset.
// - Capture read freezes both bytes until other.
// - Compare/PWM writes buffer; pair moves together.
// - Channel control write restarts byte pairing.
// - Clock select none, bus, fixed, external.
// - Halt in debug, stop in stop mode.
// - Center-align makes up/down, all channels center.
// - Up count wraps at terminal count.
// - Up/down ends last one clock each.
// - Overflow flag on terminal-to-zero wrap.
// - Overflow flag on up/down reversal at terminal count.
// - Overflow request level while flag and enable.
// - Counter read captures both bytes coherently.
// - Counter write resets count and capture.
// - Mode bits choose capture, compare or PWM.
// - Active edge copies counter into value.
// - Capture event sets channel flag.
// - Compare match drives pin, sets flag.
// - PWM: modulus period, value width, polarity.
// - Edge PWM: zero gives 0%, above modulus 100%.
// - Edge PWM duty updates at counter zero, center PWM at the up/down reversal at terminal count.
// - Capture edge select rising, falling, either.
// - Compare action none, toggle, clear, set.
// - PWM edge select picks pulse polarity.
// - Flag clears by read then zero write.
module timer_pwm_unit #(
  parameter int NCH = 2
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic [7:0]     awaddr,
  input  wire logic           awvalid,
  output var  logic           awready,
  input  wire logic [31:0]    wdata,
  input  wire logic [3:0]     wstrb,
  input  wire logic           wvalid,
  output var  logic           wready,
  output var  logic [1:0]     bresp,
  output var  logic           bvalid,
  input  wire logic           bready,
  input  wire logic [7:0]     araddr,
  input  wire logic           arvalid,
  output var  logic           arready,
  output var  logic [31:0]    rdata,
  output var  logic [1:0]     rresp,
  output var  logic           rvalid,
  input  wire logic           rready,
  input  wire logic           debug_halt,
  input  wire logic           stop_mode,
  input  wire logic           fixed_clk_tick,
  input  wire logic           ext_clk_in,
  input  wire logic [NCH-1:0] ch_pin_in,
  output var  logic [NCH-1:0] ch_pin_out,
  output var  logic [NCH-1:0] ch_pin_oe,
  output var  logic           overflow_irq,
  output var  logic [NCH-1:0] channel_irq
);

  // ************************************************************
  // Decoding helpers
  // ************************************************************

  // True when an index names register k of channel n.
  function automatic logic ch_hit(input logic [5:0] idx, input int n, input int k);
    return idx == 6'(`TMR_CH_BASE + `TMR_CH_STRIDE * n + k);
  endfunction

  // True when an index names any register of the map.
  function automatic logic mapped(input logic [5:0] idx);
    return idx < 6'(`TMR_CH_BASE + `TMR_CH_STRIDE * NCH);
  endfunction

  // Channel mode from the center-align bit and the mode select bits.
  function automatic timer_pkg::chan_mode_e mode_of(input logic cas,
                                                    input timer_pkg::ch_ctrl_s c);
    if (cas) return timer_pkg::MODE_CENTER_PWM;
    if (c.mode_select_upper) return timer_pkg::MODE_EDGE_PWM;
    if (c.mode_select_lower) return timer_pkg::MODE_COMPARE;
    return timer_pkg::MODE_CAPTURE;
  endfunction

  // ************************************************************
  // State
  // ************************************************************

  logic                   awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]             bresp_reg, rresp_reg;
  logic [7:0]             rdata_reg, aw_addr_reg, w_data_reg;
  logic                   w_strb_reg;
  logic                   tof_reg, tof_arm_reg, overflow_irq_enable_reg, cas_reg, ext_prev_reg;
  timer_pkg::clk_sel_e    clk_sel_reg;
  logic [15:0]            cnt_reg, cnt_buf_reg, mod_reg, mod_buf_reg;
  logic                   dir_up_reg, cnt_latch_reg, cnt_first_hi_reg;
  logic                   mod_hi_reg, mod_lo_reg, ovf_irq_reg;
  timer_pkg::ch_ctrl_s    ctrl_reg [NCH];
  logic [15:0]            value_reg [NCH];
  logic [15:0]            vbuf_reg [NCH];
  logic [15:0]            rbuf_reg [NCH];
  logic [NCH-1:0]         flag_reg, arm_reg, vhi_reg, vlo_reg, pend_reg;
  logic [NCH-1:0]         rlatch_reg, rfirst_hi_reg, pin_prev_reg;
  logic [NCH-1:0]         pin_out_reg, pin_oe_reg, ch_irq_reg;

  logic                   wr_go, rd_en, tick, up_wrap, reverse, tof_event;
  logic [5:0]             wr_idx, rd_idx;
  logic [15:0]            term;
  logic [7:0]             rd_byte;
  timer_pkg::chan_mode_e  mode [NCH];
  logic [NCH-1:0]         match, cap_ev, ch_ev;

  assign awready      = awready_reg;
  assign wready       = wready_reg;
  assign bvalid       = bvalid_reg;
  assign bresp        = bresp_reg;
  assign arready      = arready_reg;
  assign rvalid       = rvalid_reg;
  assign rresp        = rresp_reg;
  assign rdata        = {24'h000000, rdata_reg};
  assign overflow_irq = ovf_irq_reg;
  assign channel_irq  = ch_irq_reg;
  assign ch_pin_out   = pin_out_reg;
  assign ch_pin_oe    = pin_oe_reg;

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************

  // A write acts once address and data are both held, wstrb[0] was set and no answer is pending.
  assign wr_go  = ~awready_reg & ~wready_reg & ~bvalid_reg & w_strb_reg;
  assign wr_idx = aw_addr_reg[7:2];
  assign rd_en  = arvalid & arready_reg;
  assign rd_idx = araddr[7:2];

  // Write channels: address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TMR_RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
    end else begin
      if (awvalid && awready_reg) begin
        aw_addr_reg <= awaddr;
        awready_reg <= 1'b0;
      end
      if (wvalid && wready_reg) begin
        w_data_reg <= wdata[7:0];
        w_strb_reg <= wstrb[0];
        wready_reg <= 1'b0;
      end
      if (!awready_reg && !wready_reg && !bvalid_reg) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= mapped(wr_idx) ? `TMR_RESP_OKAY : `TMR_RESP_DEC;
      end
      if (bvalid_reg && bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Read data selection; latched buffers answer while a pair is open.
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      `TMR_IDX_CTRL: rd_byte = {tof_reg, overflow_irq_enable_reg, cas_reg, clk_sel_reg, 3'h0};
      `TMR_IDX_CNTH: rd_byte = cnt_latch_reg ? cnt_buf_reg[15:8] : cnt_reg[15:8];
      `TMR_IDX_CNTL: rd_byte = cnt_latch_reg ? cnt_buf_reg[7:0] : cnt_reg[7:0];
      `TMR_IDX_MODH: rd_byte = mod_reg[15:8];
      `TMR_IDX_MODL: rd_byte = mod_reg[7:0];
      default: begin
        for (int n = 0; n < NCH; n++) begin
          if (ch_hit(rd_idx, n, `TMR_CH_CTRL))
            rd_byte = {flag_reg[n], ctrl_reg[n], 2'h0};
          if (ch_hit(rd_idx, n, `TMR_CH_VHI))
            rd_byte = rlatch_reg[n] ? rbuf_reg[n][15:8] : value_reg[n][15:8];
          if (ch_hit(rd_idx, n, `TMR_CH_VLO))
            rd_byte = rlatch_reg[n] ? rbuf_reg[n][7:0] : value_reg[n][7:0];
        end
      end
    endcase
  end

  // Read channel: the answer is registered at the edge that takes the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 8'h00;
      rresp_reg   <= `TMR_RESP_OKAY;
    end else if (rd_en) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_byte;
      rresp_reg   <= mapped(rd_idx) ? `TMR_RESP_OKAY : `TMR_RESP_DEC;
    end else if (rvalid_reg && rready) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************

  // Counting clock enable from the selected source, held off in debug and stop.
  always_comb begin
    unique case (clk_sel_reg)
      timer_pkg::CLK_BUS:   tick = 1'b1;
      timer_pkg::CLK_FIXED: tick = fixed_clk_tick;
      timer_pkg::CLK_EXT:   tick = ext_clk_in & ~ext_prev_reg;
      default:              tick = 1'b0;
    endcase
    tick = tick & ~debug_halt & ~stop_mode;
  end

  assign term      = (mod_reg == 16'h0000) ? `TMR_CNT_MAX : mod_reg;
  assign up_wrap   = tick & ~cas_reg & (cnt_reg == term);
  assign reverse   = tick & cas_reg & dir_up_reg & (cnt_reg == term);
  assign tof_event = up_wrap | reverse;

  // Counter steps; a write to either counter byte restarts it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg    <= `TMR_CNT_RST;
      dir_up_reg <= 1'b1;
    end else if (wr_go && (wr_idx == `TMR_IDX_CNTH || wr_idx == `TMR_IDX_CNTL)) begin
      cnt_reg    <= `TMR_CNT_RST;
      dir_up_reg <= 1'b1;
    end else if (tick) begin
      if (!cas_reg) begin
        cnt_reg <= up_wrap ? `TMR_CNT_RST : cnt_reg + 16'h0001;
      end else if (dir_up_reg) begin
        if (cnt_reg == term) begin
          cnt_reg    <= cnt_reg - 16'h0001;
          dir_up_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end else if (cnt_reg == 16'h0000) begin
        cnt_reg    <= 16'h0001;
        dir_up_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

  // Counter read capture: the first byte read freezes both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_latch_reg    <= 1'b0;
      cnt_first_hi_reg <= 1'b0;
      cnt_buf_reg      <= `TMR_CNT_RST;
    end else if (wr_go && (wr_idx == `TMR_IDX_CNTH || wr_idx == `TMR_IDX_CNTL)) begin
      cnt_latch_reg <= 1'b0;
    end else if (rd_en && (rd_idx == `TMR_IDX_CNTH || rd_idx == `TMR_IDX_CNTL)) begin
      if (!cnt_latch_reg) begin
        cnt_latch_reg    <= 1'b1;
        cnt_first_hi_reg <= rd_idx == `TMR_IDX_CNTH;
        cnt_buf_reg      <= cnt_reg;
      end else if ((rd_idx == `TMR_IDX_CNTH) != cnt_first_hi_reg) begin
        cnt_latch_reg <= 1'b0;
      end
    end
  end

  // Timer control and overflow flag; a new overflow beats the clearing write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tof_reg      <= 1'b0;
      tof_arm_reg  <= 1'b0;
      overflow_irq_enable_reg     <= 1'b0;
      cas_reg      <= 1'b0;
      clk_sel_reg  <= timer_pkg::CLK_NONE;
      ext_prev_reg <= 1'b0;
      ovf_irq_reg  <= 1'b0;
    end else begin
      ext_prev_reg <= ext_clk_in;
      ovf_irq_reg  <= tof_reg & overflow_irq_enable_reg;
      if (wr_go && wr_idx == `TMR_IDX_CTRL) begin
        overflow_irq_enable_reg    <= w_data_reg[`TMR_OVERFLOW_IRQ_ENABLE_BIT];
        cas_reg     <= w_data_reg[`TMR_CAS_BIT];
        clk_sel_reg <= timer_pkg::clk_sel_e'(w_data_reg[`TMR_CLKS_HI:`TMR_CLKS_LO]);
      end
      if (tof_event) begin
        tof_reg     <= 1'b1;
        tof_arm_reg <= 1'b0;
      end else begin
        if (rd_en && rd_idx == `TMR_IDX_CTRL && tof_reg)
          tof_arm_reg <= 1'b1;
        if (wr_go && wr_idx == `TMR_IDX_CTRL && !w_data_reg[`TMR_TOF_BIT] && tof_arm_reg) begin
          tof_reg     <= 1'b0;
          tof_arm_reg <= 1'b0;
        end
      end
    end
  end

  // Modulus pairing: both bytes move together; a control write drops a half pair.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_reg     <= `TMR_CNT_RST;
      mod_buf_reg <= `TMR_CNT_RST;
      mod_hi_reg  <= 1'b0;
      mod_lo_reg  <= 1'b0;
    end else if (wr_go && wr_idx == `TMR_IDX_CTRL) begin
      mod_hi_reg <= 1'b0;
      mod_lo_reg <= 1'b0;
    end else if (wr_go && wr_idx == `TMR_IDX_MODH) begin
      mod_buf_reg[15:8] <= w_data_reg;
      mod_hi_reg        <= ~mod_lo_reg;
      mod_lo_reg        <= 1'b0;
      if (mod_lo_reg)
        mod_reg <= {w_data_reg, mod_buf_reg[7:0]};
    end else if (wr_go && wr_idx == `TMR_IDX_MODL) begin
      mod_buf_reg[7:0] <= w_data_reg;
      mod_lo_reg       <= ~mod_hi_reg;
      mod_hi_reg       <= 1'b0;
      if (mod_hi_reg)
        mod_reg <= {mod_buf_reg[15:8], w_data_reg};
    end
  end

  // ************************************************************
  // Channels
  // ************************************************************

  // Per-channel mode, compare match and selected capture edge.
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      mode[n]  = mode_of(cas_reg, ctrl_reg[n]);
      match[n] = tick & (cnt_reg == value_reg[n]) & (mode[n] != timer_pkg::MODE_CAPTURE);
      unique case (ctrl_reg[n].edge_level_select)
        2'h1:    cap_ev[n] = ch_pin_in[n] & ~pin_prev_reg[n];
        2'h2:    cap_ev[n] = ~ch_pin_in[n] & pin_prev_reg[n];
        2'h3:    cap_ev[n] = ch_pin_in[n] ^ pin_prev_reg[n];
        default: cap_ev[n] = 1'b0;
      endcase
      cap_ev[n] = cap_ev[n] & (mode[n] == timer_pkg::MODE_CAPTURE);
      ch_ev[n]  = cap_ev[n] | match[n];
    end
  end

  // Channel configuration and flags; an event beats the clearing write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg     <= '0;
      arm_reg      <= '0;
      ch_irq_reg   <= '0;
      pin_prev_reg <= '0;
      for (int n = 0; n < NCH; n++)
        ctrl_reg[n] <= '0;
    end else begin
      pin_prev_reg <= ch_pin_in;
      for (int n = 0; n < NCH; n++) begin
        ch_irq_reg[n] <= flag_reg[n] & ctrl_reg[n].channel_irq_enable;
        if (wr_go && ch_hit(wr_idx, n, `TMR_CH_CTRL))
          ctrl_reg[n] <= timer_pkg::ch_ctrl_s'(w_data_reg[`TMR_CHCFG_HI:`TMR_CHCFG_LO]);
        if (ch_ev[n]) begin
          flag_reg[n] <= 1'b1;
          arm_reg[n]  <= 1'b0;
        end else begin
          if (rd_en && ch_hit(rd_idx, n, `TMR_CH_CTRL) && flag_reg[n])
            arm_reg[n] <= 1'b1;
          if (wr_go && ch_hit(wr_idx, n, `TMR_CH_CTRL) && arm_reg[n]
              && !w_data_reg[`TMR_CHF_BIT]) begin
            flag_reg[n] <= 1'b0;
            arm_reg[n]  <= 1'b0;
          end
        end
      end
    end
  end

  // Channel value: capture, paired writes and the buffered PWM update.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vhi_reg  <= '0;
      vlo_reg  <= '0;
      pend_reg <= '0;
      for (int n = 0; n < NCH; n++) begin
        value_reg[n] <= `TMR_VAL_RST;
        vbuf_reg[n]  <= `TMR_VAL_RST;
      end
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (cap_ev[n])
          value_reg[n] <= cnt_reg;
        if (pend_reg[n] && (mode[n] == timer_pkg::MODE_EDGE_PWM ? cnt_reg == 16'h0000
                                                                 : reverse)) begin
          value_reg[n] <= vbuf_reg[n];
          pend_reg[n]  <= 1'b0;
        end
        if (wr_go && ch_hit(wr_idx, n, `TMR_CH_CTRL)) begin
          vhi_reg[n]  <= 1'b0;
          vlo_reg[n]  <= 1'b0;
          pend_reg[n] <= 1'b0;
        end else if (wr_go && (ch_hit(wr_idx, n, `TMR_CH_VHI) ||
                               ch_hit(wr_idx, n, `TMR_CH_VLO))) begin
          if (ch_hit(wr_idx, n, `TMR_CH_VHI)) begin
            vbuf_reg[n][15:8] <= w_data_reg;
            vhi_reg[n]        <= ~vlo_reg[n];
            vlo_reg[n]        <= 1'b0;
          end else begin
            vbuf_reg[n][7:0] <= w_data_reg;
            vlo_reg[n]       <= ~vhi_reg[n];
            vhi_reg[n]       <= 1'b0;
          end
          if (ch_hit(wr_idx, n, `TMR_CH_VHI) ? vlo_reg[n] : vhi_reg[n]) begin
            if (mode[n] == timer_pkg::MODE_EDGE_PWM || mode[n] == timer_pkg::MODE_CENTER_PWM)
              pend_reg[n] <= 1'b1;
            else if (ch_hit(wr_idx, n, `TMR_CH_VHI))
              value_reg[n] <= {w_data_reg, vbuf_reg[n][7:0]};
            else
              value_reg[n] <= {vbuf_reg[n][15:8], w_data_reg};
          end
        end
      end
    end
  end

  // Capture read pairing: the first byte read freezes both bytes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rlatch_reg    <= '0;
      rfirst_hi_reg <= '0;
      for (int n = 0; n < NCH; n++)
        rbuf_reg[n] <= `TMR_VAL_RST;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (wr_go && ch_hit(wr_idx, n, `TMR_CH_CTRL)) begin
          rlatch_reg[n] <= 1'b0;
        end else if (rd_en && mode[n] == timer_pkg::MODE_CAPTURE &&
                     (ch_hit(rd_idx, n, `TMR_CH_VHI) || ch_hit(rd_idx, n, `TMR_CH_VLO))) begin
          if (!rlatch_reg[n]) begin
            rlatch_reg[n]    <= 1'b1;
            rfirst_hi_reg[n] <= ch_hit(rd_idx, n, `TMR_CH_VHI);
            rbuf_reg[n]      <= value_reg[n];
          end else if (ch_hit(rd_idx, n, `TMR_CH_VHI) != rfirst_hi_reg[n]) begin
            rlatch_reg[n] <= 1'b0;
          end
        end
      end
    end
  end

  // Pin drive for compare and PWM; the pin is released in capture or with 00.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_reg <= '0;
      pin_oe_reg  <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        pin_oe_reg[n] <= (mode[n] != timer_pkg::MODE_CAPTURE) &&
                         (ctrl_reg[n].edge_level_select != 2'h0);
        unique case (mode[n])
          timer_pkg::MODE_COMPARE: begin
            if (match[n]) begin
              unique case (ctrl_reg[n].edge_level_select)
                2'h1:    pin_out_reg[n] <= ~pin_out_reg[n];
                2'h2:    pin_out_reg[n] <= 1'b0;
                2'h3:    pin_out_reg[n] <= 1'b1;
                default: pin_out_reg[n] <= pin_out_reg[n];
              endcase
            end
          end
          timer_pkg::MODE_EDGE_PWM: begin
            if (up_wrap)
              pin_out_reg[n] <= (value_reg[n] == 16'h0000) ? ctrl_reg[n].edge_level_select[0]
                                                           : ~ctrl_reg[n].edge_level_select[0];
            else if (match[n])
              pin_out_reg[n] <= ctrl_reg[n].edge_level_select[0];
          end
          timer_pkg::MODE_CENTER_PWM: begin
            if (match[n])
              pin_out_reg[n] <= dir_up_reg ? ctrl_reg[n].edge_level_select[0]
                                           : ~ctrl_reg[n].edge_level_select[0];
            else if (reverse && (value_reg[n] == 16'h0000 || value_reg[n][15]))
              pin_out_reg[n] <= ctrl_reg[n].edge_level_select[0];
          end
          default: pin_out_reg[n] <= pin_out_reg[n];
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== verif/timer_pwm_unit_sva.sv ====
// Port-level assertions for the timer.
`default_nettype none
module timer_pwm_unit_sva #(
  parameter int NCH = 2
) (
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic           awready,
  input wire logic           wready,
  input wire logic           bvalid,
  input wire logic           arvalid,
  input wire logic           arready,
  input wire logic           rvalid,
  input wire logic           debug_halt,
  input wire logic           stop_mode,
  input wire logic [NCH-1:0] ch_pin_out,
  input wire logic [NCH-1:0] ch_pin_oe,
  input wire logic           overflow_irq,
  input wire logic [NCH-1:0] channel_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pins and requests start released and quiet.
  property p_rst; $rose(aresetn) |-> !ch_pin_oe && !channel_irq && !overflow_irq; endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
  // A suspended counter moves no pin unless software writes.
  property p_dbg; debug_halt && awready && wready |=> $stable(ch_pin_out); endproperty
  a_dbg: assert property (p_dbg) else $error("pin moved in debug halt");
  property p_stop; stop_mode && awready && wready |=> $stable(ch_pin_out); endproperty
  a_stop: assert property (p_stop) else $error("pin moved in stop mode");
  // Requests drop only after a software write.
  property p_ofall; $fell(overflow_irq) |-> $past(bvalid); endproperty
  a_ofall: assert property (p_ofall) else $error("overflow request dropped alone");
  property p_cfall; |($past(channel_irq) & ~channel_irq) |-> $past(bvalid); endproperty
  a_cfall: assert property (p_cfall) else $error("channel request dropped alone");
  // An overflow request needs a counting tick or a write.
  property p_orise;
    $rose(overflow_irq) |-> $past(bvalid) || (!$past(debug_halt, 2) && !$past(stop_mode, 2));
  endproperty
  a_orise: assert property (p_orise) else $error("overflow request while halted");
  // Pin release follows control writes only.
  property p_oe; $changed(ch_pin_oe) |-> bvalid || $past(bvalid); endproperty
  a_oe: assert property (p_oe) else $error("pin enable moved alone");
  property p_rd; arvalid && arready |=> rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
endmodule
bind timer_pwm_unit timer_pwm_unit_sva #(.NCH(NCH)) u_sva (.*);
`default_nettype wire

// ==== verif/chan_pin_model.sv ====
// Outside sources on the channel pins.
`default_nettype none
module chan_pin_model #(
  parameter int NCH = 2
) (
  input  wire logic [NCH-1:0] pin_out,
  input  wire logic [NCH-1:0] pin_oe,
  input  wire logic [NCH-1:0] ext_lvl,
  output var  logic [NCH-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin shows the timer's level, a released one the outside level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking testbench for the timer.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, overflow_irq;
  logic        debug_halt, stop_mode, fixed_clk_tick, ext_clk_in;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, ch_pin_in, ch_pin_out, ch_pin_oe, channel_irq, ext_lvl, rsp;
  int          err_total, n_compared;
  timer_pwm_unit u_timer_pwm_unit (.*);
  chan_pin_model u_chan_pin_model (.pin_out(ch_pin_out), .pin_oe(ch_pin_oe),
                                   .ext_lvl(ext_lvl), .pin_in(ch_pin_in));
  // Free-running 50 MHz clock.
  always #10 aclk = ~aclk;
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  // One AXI4-Lite transfer; each channel is released at its own handshake, bready and rready stay high.
  task automatic bus(input bit w, input logic [5:0] i, input logic [7:0] wd,
                     output logic [7:0] rd);
    logic a, b, fin;
    fin = 1'h0;
    if (w) begin
      awaddr <= {i, 2'h0};
      wdata <= {24'h0, wd};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
    end else begin
      araddr <= {i, 2'h0};
      arvalid <= 1'h1;
    end
    for (int n = 0; n < 50 && !fin; n++) begin
      @(negedge aclk);
      a = w ? awvalid && awready : arvalid && arready;
      b = wvalid && wready;
      fin = w ? bvalid : rvalid;
      rd = rdata[7:0];
      rsp = w ? bresp : rresp;
      @(posedge aclk);
      if (w && a) awvalid <= 1'h0;
      if (w && b) wvalid <= 1'h0;
      if (!w && a) arvalid <= 1'h0;
    end
    if (!fin) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] x;
    bus(1'h1, i, d, x);
  endtask
  task automatic rc(input logic [5:0] i, input logic [7:0] e, input string s);
    logic [7:0] x;
    bus(1'h0, i, 8'h00, x);
    cmp(s, e, x);
  endtask
  // Main sequence; indices: 0 control, 1-2 counter, 3-4 modulus, then 3 per channel.
  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {awvalid, wvalid, arvalid, debug_halt, stop_mode} = '0;
    {bready, rready} = 2'h3;
    {fixed_clk_tick, ext_clk_in, awaddr, araddr, wdata, ext_lvl} = '0;
    wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rc(6'h00, 8'h00, "tmr_ctrl");
    rc(6'h06, 8'h00, "val0_hi");
    rc(6'h07, 8'h00, "val0_lo");
    rc(6'h28, 8'h00, "unmapped");
    cmp("rresp", 8'h03, {6'h0, rsp});
    wr(6'h05, 8'h1c);
    cmp("bresp", 8'h00, {6'h0, rsp});
    wr(6'h06, 8'h12);
    wr(6'h05, 8'h1c);
    wr(6'h07, 8'h05);
    rc(6'h07, 8'h00, "val0_half");
    wr(6'h06, 8'h00);
    rc(6'h07, 8'h05, "val0_pair");
    ext_lvl <= 2'h2;
    wr(6'h04, 8'h10);
    wr(6'h03, 8'h00);
    wr(6'h08, 8'h44);
    wr(6'h00, 8'h48);
    repeat (20) @(posedge aclk);
    debug_halt <= 1'h1;
    @(negedge aclk);
    cmp("ovf_irq", 8'h01, {7'h0, overflow_irq});
    cmp("pin0", 8'h01, {7'h0, ch_pin_out[0]});
    cmp("pin_oe", 8'h01, {6'h0, ch_pin_oe});
    @(posedge aclk);
    rc(6'h05, 8'h9c, "ch0_ctrl");
    rc(6'h00, 8'hc8, "tmr_flag");
    wr(6'h00, 8'h48);
    ext_lvl <= 2'h0;
    repeat (3) @(posedge aclk);
    cmp("ovf_clr", 8'h00, {7'h0, overflow_irq});
    rc(6'h08, 8'h44, "ch1_fall");
    wr(6'h01, 8'h00);
    debug_halt <= 1'h0;
    repeat (9) @(posedge aclk);
    debug_halt <= 1'h1;
    ext_lvl <= 2'h2;
    repeat (3) @(negedge aclk);
    cmp("ch1_irq", 8'h01, {7'h0, channel_irq[1]});
    @(posedge aclk);
    rc(6'h0a, 8'h09, "cap1_lo");
    rc(6'h08, 8'hc4, "ch1_flag");
    wr(6'h08, 8'h44);
    repeat (2) @(negedge aclk);
    cmp("ch1_clr", 8'h00, {7'h0, channel_irq[1]});
    @(posedge aclk);
    rc(6'h02, 8'h09, "cnt_lo");
    stop_mode <= 1'h1;
    debug_halt <= 1'h0;
    repeat (5) @(posedge aclk);
    stop_mode <= 1'h0;
    repeat (3) @(posedge aclk);
    debug_halt <= 1'h1;
    rc(6'h02, 8'h09, "cnt_frozen");
    rc(6'h01, 8'h00, "cnt_hi");
    rc(6'h02, 8'h0c, "cnt_fresh");
    // Edge PWM on channel 0, counted from the external clock at a quarter of the bus rate.
    wr(6'h05, 8'h28);
    wr(6'h00, 8'h58);
    wr(6'h01, 8'h00);
    debug_halt <= 1'h0;
    repeat (12) begin
      repeat (2) @(posedge aclk);
      ext_clk_in <= ~ext_clk_in;
    end
    rc(6'h02, 8'h06, "ext_cnt");
    cmp("pwm0", 8'h00, {7'h0, ch_pin_out[0]});
    wrap_up();
  end
endmodule
`default_nettype wire
